/* File: hdl/boot_strap_pkg.sv */
package boot_strap_pkg;

  // Strap vector layout
  localparam int STRAP_W  = 9;
  localparam int POS_CLK  = 0;
  localparam int POS_DAT  = 1;
  localparam int POS_MOD0 = 2;
  localparam int POS_MOD1 = 3;
  localparam int POS_SYNC = 4;
  localparam int POS_WID0 = 5;
  localparam int POS_WID1 = 6;
  localparam int POS_WDT  = 7;
  localparam int POS_RDUR = 8;

  // Register map, byte addresses
  localparam int          ADR_W      = 4;
  localparam logic [3:0]  ADR_STATUS = 4'h0;
  localparam logic [3:0]  ADR_STRAPS = 4'h4;
  localparam logic [3:0]  ADR_CTRL   = 4'h8;

  // Status register fields
  localparam int ST_VALID  = 0;
  localparam int ST_SRC_LO = 1;
  localparam int ST_WID_LO = 4;
  localparam int ST_SYNC   = 6;
  localparam int ST_EXT    = 7;
  localparam int ST_WDT    = 8;
  localparam int ST_RDUR   = 9;
  localparam int ST_USER   = 10;

  // Control register fields and reset value
  localparam int          CTRL_KILL = 0;
  localparam logic        RST_KILL  = 1'h0;
  localparam logic [31:0] RST_DATA  = 32'h0000_0000;

  // Mode and width encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SERIAL = 2'h1;
  localparam logic [1:0] WIDTH_8     = 2'h0;
  localparam logic [1:0] WIDTH_16    = 2'h1;

  typedef enum logic [2:0] {
    SRC_NONE      = 3'h0,
    SRC_SYNC_EXT  = 3'h1,
    SRC_ASYNC_EXT = 3'h2,
    SRC_NOR       = 3'h3,
    SRC_INT_ROM   = 3'h4,
    SRC_SERIAL    = 3'h5,
    SRC_RESERVED  = 3'h6
  } boot_src_e;

  typedef enum logic {
    CAP_WAIT = 1'b0,
    CAP_HELD = 1'b1
  } cap_state_e;

endpackage : boot_strap_pkg

/* File: hdl/strap_sync2.sv */
module strap_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // System clock
  input  wire logic             arst_n, // Async reset
  input  wire logic [WIDTH-1:0] d,      // Asynchronous inputs
  output logic      [WIDTH-1:0] q       // Synchronised outputs
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = d;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.sync;

endmodule : strap_sync2

/* File: hdl/boot_config_strap_latch.sv */
// How it works
// - Straps latched on rising edge of power-on or user reset.
// - Serial EEPROM clock strap picks internal versus external boot.
// - Sync select strap picks synchronous versus asynchronous boot.
// - Clock 0, mode 00, sync 1: external synchronous memory boot.
// - Clock 0, mode 00, sync 0: external async boot on chip select 0.
// - Clock 1, mode 00, sync 1: NOR flash boot, not flagged external.
// - Clock 1, mode 00, sync 0: internal on-chip ROM boot.
// - Only 16-bit NOR and serial boot are user modes.
// - Two-bit width straps latched as the external boot bus width.
// - Watchdog strap 0 starts watchdog disabled, 1 starts it active.
// - Reset duration strap 0 disables the feature, 1 keeps it.
module boot_config_strap_latch (
  input  wire logic        clk,                        // 50 MHz clock
  input  wire logic        arst_n,                     // Async reset
  input  wire logic        power_on_reset_n,           // Reset pin
  input  wire logic        user_reset_n,               // Reset pin
  input  wire logic        serial_eeprom_clock_strap,  // Strap pin
  input  wire logic        serial_eeprom_data_strap,   // Strap pin
  input  wire logic [1:0]  boot_mode_straps,           // Strap pins
  input  wire logic        sync_select_strap,          // Strap pin
  input  wire logic [1:0]  boot_width_straps,          // Strap pins
  input  wire logic        watchdog_enable_strap,      // Strap pin
  input  wire logic        reset_duration_strap,       // Strap pin
  input  wire logic        wb_cyc,                     // Bus cycle
  input  wire logic        wb_stb,                     // Bus strobe
  input  wire logic        wb_we,                      // Write enable
  input  wire logic [3:0]  wb_adr,                     // Byte address
  input  wire logic [3:0]  wb_sel,                     // Byte lanes
  input  wire logic [31:0] wb_dat_w,                   // Write data
  output logic      [31:0] wb_dat_r,                   // Read data
  output logic             wb_ack,                     // Acknowledge
  output logic             config_valid,               // Straps latched
  output logic      [2:0]  boot_source,                // Boot source
  output logic      [1:0]  boot_width,                 // Width code
  output logic             boot_sync,                  // Sync boot
  output logic             boot_external,              // External boot
  output logic             wdt_enable,                 // Watchdog on
  output logic             reset_duration_enable,      // Duration on
  output logic             user_mode                   // User boot mode
);

  localparam int SW = boot_strap_pkg::STRAP_W;

  typedef struct packed {
    boot_strap_pkg::cap_state_e cap;
    logic [1:0]                 rst_prev;
    logic [SW-1:0]              raw;
    boot_strap_pkg::boot_src_e  src;
    logic [1:0]                 width;
    logic                       sync_boot;
    logic                       external;
    logic                       wdt_en;
    logic                       rdur_en;
    logic                       user;
    logic                       valid;
    logic                       wdt_kill;
    logic                       ack;
    logic [31:0]                dat;
  } state_s;

  state_s        s_reg;
  state_s        s_next;
  logic [SW+1:0] pins_sync;
  logic [SW-1:0] strap_sync;
  logic [1:0]    rst_sync;
  logic [1:0]    rst_rise;
  logic          capture;
  logic          acc;
  logic          kill_set;
  logic [31:0]   rd_data;

  strap_sync2 #(
    .WIDTH (SW + 2)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({power_on_reset_n, user_reset_n,
              reset_duration_strap, watchdog_enable_strap,
              boot_width_straps, sync_select_strap,
              boot_mode_straps, serial_eeprom_data_strap,
              serial_eeprom_clock_strap}),
    .q      (pins_sync)
  );

  assign strap_sync = pins_sync[SW-1:0];
  assign rst_sync   = pins_sync[SW+1:SW];

  // Boot source from one strap vector
  function automatic boot_strap_pkg::boot_src_e decode_src(
    input logic [SW-1:0] r
  );
    logic [1:0] mode;
    logic [1:0] wid;
    boot_strap_pkg::boot_src_e res;
    mode = {r[boot_strap_pkg::POS_MOD1], r[boot_strap_pkg::POS_MOD0]};
    wid  = {r[boot_strap_pkg::POS_WID1], r[boot_strap_pkg::POS_WID0]};
    res  = boot_strap_pkg::SRC_RESERVED;
    if (r[boot_strap_pkg::POS_DAT]) begin
      if (mode == boot_strap_pkg::MODE_NORMAL && !wid[1]) begin
        unique case ({r[boot_strap_pkg::POS_CLK],
                      r[boot_strap_pkg::POS_SYNC]})
          2'b01: res = boot_strap_pkg::SRC_SYNC_EXT;
          2'b00: res = boot_strap_pkg::SRC_ASYNC_EXT;
          2'b11: res = boot_strap_pkg::SRC_NOR;
          2'b10: res = boot_strap_pkg::SRC_INT_ROM;
        endcase
      end else if (mode == boot_strap_pkg::MODE_SERIAL &&
                   r[boot_strap_pkg::POS_CLK] &&
                   wid == boot_strap_pkg::WIDTH_16) begin
        res = boot_strap_pkg::SRC_SERIAL;
      end
    end
    return res;
  endfunction : decode_src

  always_comb begin
    rst_rise = rst_sync & ~s_reg.rst_prev;
    capture  = |rst_rise;
    acc      = wb_cyc && wb_stb && !s_reg.ack;
    kill_set = acc && wb_we && wb_sel[0] &&
               wb_adr == boot_strap_pkg::ADR_CTRL &&
               wb_dat_w[boot_strap_pkg::CTRL_KILL];
    rd_data  = boot_strap_pkg::RST_DATA;
    unique case (wb_adr)
      boot_strap_pkg::ADR_STATUS: begin
        rd_data[boot_strap_pkg::ST_VALID]                    = s_reg.valid;
        rd_data[boot_strap_pkg::ST_SRC_LO +: 3]              = s_reg.src;
        rd_data[boot_strap_pkg::ST_WID_LO +: 2]              = s_reg.width;
        rd_data[boot_strap_pkg::ST_SYNC]                     = s_reg.sync_boot;
        rd_data[boot_strap_pkg::ST_EXT]                      = s_reg.external;
        rd_data[boot_strap_pkg::ST_WDT]                      = s_reg.wdt_en;
        rd_data[boot_strap_pkg::ST_RDUR]                     = s_reg.rdur_en;
        rd_data[boot_strap_pkg::ST_USER]                     = s_reg.user;
      end
      boot_strap_pkg::ADR_STRAPS: rd_data[SW-1:0]            = s_reg.raw;
      boot_strap_pkg::ADR_CTRL:
        rd_data[boot_strap_pkg::CTRL_KILL]                   = s_reg.wdt_kill;
      default: rd_data = boot_strap_pkg::RST_DATA;
    endcase

    s_next          = s_reg;
    s_next.rst_prev = rst_sync;
    s_next.ack      = acc;
    s_next.dat      = acc ? rd_data : boot_strap_pkg::RST_DATA;

    if (capture) begin
      s_next.raw   = strap_sync;
      s_next.cap   = boot_strap_pkg::CAP_HELD;
      s_next.valid = 1'b1;
    end
    // no other path writes the latch

    // Kill set wins over the clear at capture
    if (capture) begin
      s_next.wdt_kill = boot_strap_pkg::RST_KILL;
    end
    if (kill_set) begin
      s_next.wdt_kill = 1'b1;
    end

    s_next.src = (s_next.cap == boot_strap_pkg::CAP_HELD) ?
                 decode_src(s_next.raw) : boot_strap_pkg::SRC_NONE;
    s_next.width = {s_next.raw[boot_strap_pkg::POS_WID1],
                    s_next.raw[boot_strap_pkg::POS_WID0]};
    s_next.sync_boot = s_next.raw[boot_strap_pkg::POS_SYNC];
    s_next.external  = s_next.valid && !s_next.raw[boot_strap_pkg::POS_CLK];
    s_next.wdt_en    = s_next.raw[boot_strap_pkg::POS_WDT] &&
                       !s_next.wdt_kill;
    s_next.rdur_en   = s_next.raw[boot_strap_pkg::POS_RDUR];
    s_next.user = (s_next.src == boot_strap_pkg::SRC_NOR &&
                   s_next.width == boot_strap_pkg::WIDTH_16) ||
                  s_next.src == boot_strap_pkg::SRC_SERIAL;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg          <= '0;
      s_reg.cap      <= boot_strap_pkg::CAP_WAIT;
      s_reg.src      <= boot_strap_pkg::SRC_NONE;
      s_reg.wdt_kill <= boot_strap_pkg::RST_KILL;
      s_reg.dat      <= boot_strap_pkg::RST_DATA;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_r              = s_reg.dat;
  assign wb_ack                = s_reg.ack;
  assign config_valid          = s_reg.valid;
  assign boot_source           = s_reg.src;
  assign boot_width            = s_reg.width;
  assign boot_sync             = s_reg.sync_boot;
  assign boot_external         = s_reg.external;
  assign wdt_enable            = s_reg.wdt_en;
  assign reset_duration_enable = s_reg.rdur_en;
  assign user_mode             = s_reg.user;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  localparam logic [SW-1:0] CARE_NORM = 9'h05F;
  localparam logic [SW-1:0] CARE_SER  = 9'h06F;
  localparam logic [SW-1:0] V_SYNCEXT = 9'h012;
  localparam logic [SW-1:0] V_ASYNC   = 9'h002;
  localparam logic [SW-1:0] V_NOR     = 9'h013;
  localparam logic [SW-1:0] V_INTROM  = 9'h003;
  localparam logic [SW-1:0] V_SERIAL  = 9'h027;

  sequence s_capture;
    capture ##1 config_valid;
  endsequence

  property p_decode(logic [SW-1:0] care, logic [SW-1:0] val,
                    logic [2:0] exp);
    capture && ((strap_sync & care) == val) |=> boot_source == exp;
  endproperty

  AST_CAPTURE: assert property (
    capture |=> config_valid && s_reg.raw == $past(strap_sync))
    else $error("straps not latched on reset rise");

  AST_HOLD: assert property (
    !capture |=> $stable(s_reg.raw) && $stable(boot_source))
    else $error("latched straps changed without reset rise");

  AST_EXTERNAL: assert property (
    capture |=> boot_external == !$past(strap_sync[0]))
    else $error("external boot not set from clock strap");

  AST_SYNC: assert property (
    s_capture |-> boot_sync == $past(strap_sync[boot_strap_pkg::POS_SYNC]))
    else $error("sync boot not set from sync select strap");

  AST_SYNC_EXT: assert property (
    p_decode(CARE_NORM, V_SYNCEXT, boot_strap_pkg::SRC_SYNC_EXT))
    else $error("sync external boot not decoded");

  AST_ASYNC_EXT: assert property (
    p_decode(CARE_NORM, V_ASYNC, boot_strap_pkg::SRC_ASYNC_EXT))
    else $error("async external boot not decoded");

  AST_NOR: assert property (
    p_decode(CARE_NORM, V_NOR, boot_strap_pkg::SRC_NOR))
    else $error("NOR boot not decoded");

  AST_INT_ROM: assert property (
    p_decode(CARE_NORM, V_INTROM, boot_strap_pkg::SRC_INT_ROM))
    else $error("internal ROM boot not decoded");

  AST_SERIAL: assert property (
    p_decode(CARE_SER, V_SERIAL, boot_strap_pkg::SRC_SERIAL))
    else $error("serial boot not decoded");

  AST_USER: assert property (
    user_mode |-> (boot_source == boot_strap_pkg::SRC_SERIAL) ||
                  (boot_source == boot_strap_pkg::SRC_NOR &&
                   boot_width == boot_strap_pkg::WIDTH_16))
    else $error("user mode flagged for factory configuration");

  AST_WIDTH: assert property (
    capture |=> boot_width == $past(strap_sync[6:5]))
    else $error("boot width not taken from width straps");

  AST_WDT: assert property (
    capture && !kill_set |=> wdt_enable == $past(strap_sync[7]))
    else $error("watchdog start-up state wrong");

  AST_RDUR: assert property (
    capture |=> reset_duration_enable == $past(strap_sync[8]))
    else $error("reset duration start-up state wrong");

  AST_ACK: assert property (
    acc |=> wb_ack ##1 !wb_ack)
    else $error("bus ack not a single cycle");

  AST_KILL: assert property (
    kill_set |=> !wdt_enable)
    else $error("watchdog kill write ignored");

  AST_DAT_IDLE: assert property (
    !wb_ack |-> wb_dat_r == boot_strap_pkg::RST_DATA)
    else $error("read data not zero outside ack");

  AST_DATA_LOW: assert property (
    capture && !strap_sync[boot_strap_pkg::POS_DAT] |=>
      boot_source == boot_strap_pkg::SRC_RESERVED)
    else $error("low data strap not reserved");

endmodule : boot_config_strap_latch

/* File: sim/strap_board.sv */
module strap_board (
  input  wire logic [8:0] jumper_closed,             // Closed pulls pin low
  input  wire logic       por_button,                // Power-on button
  input  wire logic       user_button,               // User reset button
  output logic            power_on_reset_n,          // Reset pin
  output logic            user_reset_n,              // Reset pin
  output logic            serial_eeprom_clock_strap, // Strap pin
  output logic            serial_eeprom_data_strap,  // Strap pin
  output logic      [1:0] boot_mode_straps,          // Strap pins
  output logic            sync_select_strap,         // Strap pin
  output logic      [1:0] boot_width_straps,         // Strap pins
  output logic            watchdog_enable_strap,     // Strap pin
  output logic            reset_duration_strap       // Strap pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Buttons pull the reset lines low, pull-ups otherwise
  assign power_on_reset_n = !por_button;
  assign user_reset_n = !user_button;
  // Open jumper leaves the pull-up level
  assign serial_eeprom_clock_strap = !jumper_closed[0];
  assign serial_eeprom_data_strap = !jumper_closed[1];
  assign boot_mode_straps = ~jumper_closed[3:2];
  // sync media is ROM or flash
  assign sync_select_strap = !jumper_closed[4];
  assign boot_width_straps = ~jumper_closed[6:5];
  assign watchdog_enable_strap = !jumper_closed[7];
  assign reset_duration_strap = !jumper_closed[8];
endmodule : strap_board

/* File: sim/boot_config_strap_latch_tb_top.sv */
module boot_config_strap_latch_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, arst_n, por_button, user_button, wb_cyc, wb_stb, wb_we;
  logic        por_n, usr_n, s_clk, s_dat, s_sync, s_wdt, s_rdur, wb_ack;
  logic        config_valid, boot_sync, boot_external, wdt_enable;
  logic        reset_duration_enable, user_mode;
  logic [1:0]  s_mode, s_wid, boot_width;
  logic [2:0]  boot_source;
  logic [3:0]  wb_adr, wb_sel;
  logic [8:0]  jumper_closed;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  int          err_total, n_checks;

  strap_board strap_board_i (.jumper_closed(jumper_closed),
    .por_button(por_button), .user_button(user_button),
    .power_on_reset_n(por_n), .user_reset_n(usr_n),
    .serial_eeprom_clock_strap(s_clk), .serial_eeprom_data_strap(s_dat),
    .boot_mode_straps(s_mode), .sync_select_strap(s_sync),
    .boot_width_straps(s_wid), .watchdog_enable_strap(s_wdt),
    .reset_duration_strap(s_rdur));

  boot_config_strap_latch boot_config_strap_latch_i (.clk(clk),
    .arst_n(arst_n), .power_on_reset_n(por_n), .user_reset_n(usr_n),
    .serial_eeprom_clock_strap(s_clk), .serial_eeprom_data_strap(s_dat),
    .boot_mode_straps(s_mode), .sync_select_strap(s_sync),
    .boot_width_straps(s_wid), .watchdog_enable_strap(s_wdt),
    .reset_duration_strap(s_rdur), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .config_valid(config_valid),
    .boot_source(boot_source), .boot_width(boot_width),
    .boot_sync(boot_sync), .boot_external(boot_external),
    .wdt_enable(wdt_enable), .reset_duration_enable(reset_duration_enable),
    .user_mode(user_mode));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [3:0] sel, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat_w <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'h1);
    rd = wb_dat_r;
    chk(wb_ack, 1'h1);
    chk(n, 32'h2);
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
    @(posedge clk);
  endtask : wb

  // Straps settle, then one reset pin pulses low
  task automatic capture(input logic [8:0] v, input logic use_por);
    jumper_closed <= ~v;
    repeat (4) @(posedge clk);
    if (use_por) por_button <= 1'h1;
    else user_button <= 1'h1;
    repeat (4) @(posedge clk);
    por_button <= 1'h0;
    user_button <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : capture

  function automatic logic [2:0] exp_src(input logic [8:0] v);
    if (!v[1] || v[3]) return boot_strap_pkg::SRC_RESERVED;
    if (v[2]) return (v[0] && v[6:5] == 2'h1) ? boot_strap_pkg::SRC_SERIAL
                                             : boot_strap_pkg::SRC_RESERVED;
    if (v[6]) return boot_strap_pkg::SRC_RESERVED;
    if (!v[0]) return v[4] ? boot_strap_pkg::SRC_SYNC_EXT
                           : boot_strap_pkg::SRC_ASYNC_EXT;
    return v[4] ? boot_strap_pkg::SRC_NOR : boot_strap_pkg::SRC_INT_ROM;
  endfunction : exp_src

  task automatic test_modes;
    logic [8:0] v;
    logic [2:0] s;
    logic       u;
    for (int k = 0; k < 80; k++) begin
      v = {k[2] ^ k[5], k[3] ^ k[0], k[5:4], k[3], k[2:1], k < 64, k[0]};
      capture(v, k[1]);
      s = exp_src(v);
      u = (s == boot_strap_pkg::SRC_NOR && v[6:5] == 2'h1) ||
          s == boot_strap_pkg::SRC_SERIAL;
      chk(config_valid, 1'h1);
      chk(boot_source, s);
      chk(boot_width, v[6:5]);
      chk(boot_external, !v[0]);
      chk(user_mode, u);
      chk(wdt_enable, v[7]);
      chk(reset_duration_enable, v[8]);
      if (!v[0] && s != boot_strap_pkg::SRC_RESERVED) chk(boot_sync, v[4]);
      wb(1'h0, boot_strap_pkg::ADR_STATUS, 4'hF, 32'h0);
      chk(rd & 32'h7BF, {u, v[8:7], !v[0], 1'h0, v[6:5], s, 1'h1});
      wb(1'h0, boot_strap_pkg::ADR_STRAPS, 4'hF, 32'h0);
      chk(rd, {23'h0, v});
    end
    $display("test_modes done");
  endtask : test_modes

  task automatic test_hold;
    capture(9'h1B3, 1'h1);
    jumper_closed <= 9'h1FF;
    repeat (10) @(posedge clk);
    chk(boot_source, boot_strap_pkg::SRC_NOR);
    chk(user_mode, 1'h1);
    chk(wdt_enable, 1'h1);
    capture(9'h002, 1'h0);
    chk(boot_source, boot_strap_pkg::SRC_ASYNC_EXT);
    chk(wdt_enable, 1'h0);
    $display("test_hold done");
  endtask : test_hold

  task automatic test_bus;
    capture(9'h1B3, 1'h1);
    wb(1'h0, 4'hC, 4'hF, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, boot_strap_pkg::ADR_STATUS, 4'hF, 32'hFFFF_FFFF);
    wb(1'h0, boot_strap_pkg::ADR_STATUS, 4'hF, 32'h0);
    chk(rd & 32'h7BF, 32'h717);
    wb(1'h1, boot_strap_pkg::ADR_CTRL, 4'h0, 32'h1);
    chk(wdt_enable, 1'h1);
    wb(1'h0, boot_strap_pkg::ADR_CTRL, 4'hF, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, boot_strap_pkg::ADR_CTRL, 4'h1, 32'h1);
    chk(wdt_enable, 1'h0);
    wb(1'h0, boot_strap_pkg::ADR_CTRL, 4'hF, 32'h0);
    chk(rd, 32'h1);
    capture(9'h1B3, 1'h0);
    chk(wdt_enable, 1'h1);
    wb(1'h0, boot_strap_pkg::ADR_CTRL, 4'hF, 32'h0);
    chk(rd, 32'h0);
    $display("test_bus done");
  endtask : test_bus

  // Pins already high at release count as a fresh rise
  task automatic test_arst;
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk(config_valid, 1'h0);
    chk(boot_source, 3'h0);
    arst_n <= 1'h1;
    repeat (6) @(posedge clk);
    chk(config_valid, 1'h1);
    chk(boot_source, boot_strap_pkg::SRC_NOR);
    $display("test_arst done");
  endtask : test_arst

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    arst_n = 1'h0;
    por_button = 1'h0;
    user_button = 1'h0;
    jumper_closed = ~9'h1B3;
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge clk);
    test_modes();
    test_hold();
    test_bus();
    test_arst();
    test_done();
  end
endmodule : boot_config_strap_latch_tb_top
